// *** design/strobe_processor_pkg.sv ***
package strobe_processor_pkg;
  localparam int MEM_DEPTH = 24;
  localparam logic [7:0] NOP_OPCODE = 8'hC0;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [7:0] OP_COMPARE_WAIT = 8'hB8;
  localparam logic [7:0] OP_INTERRUPT = 8'hB9;
  localparam logic [7:0] OP_LABEL = 8'hBA;
  localparam logic [7:0] OP_REG_WAIT = 8'hBB;
  localparam logic [7:0] OP_RANDOM = 8'hBC;
  localparam logic [7:0] OP_INC_Y = 8'hBD;
  localparam logic [7:0] OP_DEC_Y = 8'hBE;
  localparam logic [7:0] OP_DEC_Z = 8'hBF;
  localparam logic [2:0] PFX_FIXED_WAIT = 3'h4;
  localparam logic [2:0] PFX_PROG_STROBE = 3'h6;
  localparam logic [2:0] PFX_IMM_STROBE = 3'h7;
  localparam logic [3:0] PFX_REPEAT = 4'hA;
  localparam logic [4:0] PFX_CAPPED_INC = 5'h16;
  localparam int INVERT_BIT = 3;
  localparam logic [5:0] FIXED_WAIT_ZERO_COUNT = 6'h20;
  // Strobe selectors that control the processor itself; other selectors, and run in a program strobe, go to the radio
  localparam logic [4:0] SEL_RUN = 5'h1E;
  localparam logic [4:0] SEL_HALT = 5'h1F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_ISSUE = 3'b011,
    ST_WAIT_OVF = 3'b010,
    ST_WAIT_X = 3'b110,
    ST_WAIT_CMP = 3'b111
  } run_state_e;
endpackage

// *** design/instruction_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module instruction_store #(
  parameter int DEPTH = 24,
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] FILL = '0,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic clr,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [DEPTH-1:0][WIDTH-1:0] mem;
  logic [DEPTH-1:0][WIDTH-1:0] next_mem;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_cell
      // Clear beats a write in the same cycle
      assign next_mem[i] = clr ? FILL :
                           (wr_en && (wr_addr == AW'(i))) ? wr_data : mem[i];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem <= {DEPTH{FILL}};
    end else begin
      mem <= next_mem;
    end
  end

  // Out-of-range index reads as fill rather than unknown
  assign rd_data = (32'(rd_addr) < DEPTH) ? mem[rd_addr] : FILL;
endmodule
`default_nettype wire

// *** design/radio_strobe_coprocessor.sv ***
`timescale 1ns/1ps
`default_nettype none
module radio_strobe_coprocessor #(
  parameter int MEM_DEPTH = strobe_processor_pkg::MEM_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_wr,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port_rdata,
  input wire logic x_wr,
  input wire logic [7:0] x_wdata,
  input wire logic y_wr,
  input wire logic [7:0] y_wdata,
  input wire logic z_wr,
  input wire logic [7:0] z_wdata,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  output logic [7:0] param_x,
  output logic [7:0] param_y,
  output logic [7:0] param_z,
  output logic [7:0] overflow_countdown,
  input wire logic mac_overflow,
  input wire logic timer_at_compare,
  input wire logic [7:0] condition_in,
  input wire logic [7:0] random_in,
  output logic strobe_valid,
  output logic [4:0] strobe_sel,
  input wire logic strobe_ready,
  output logic running,
  output logic halt_flag,
  output logic wait_done_flag,
  output logic program_interrupt_flag
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam logic [AW:0] ONE_W = (AW+1)'(1);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(MEM_DEPTH);
  localparam logic [AW-1:0] ADDR_ZERO = '0;

  strobe_processor_pkg::run_state_e state, next_state;
  logic [AW-1:0] pc, next_pc;
  logic [AW-1:0] wptr, next_wptr;
  logic [AW-1:0] label, next_label;
  logic [7:0] next_x, next_y, next_z, next_cnt;
  logic [5:0] wait_cnt, next_wait_cnt;
  logic autodec, next_autodec;
  logic imm_pend, next_imm_pend;
  logic [4:0] imm_sel, next_imm_sel;
  logic [4:0] prog_sel, next_prog_sel;
  logic [7:0] next_rdata;
  logic next_halt, next_wdone, next_pint;
  logic mem_wr, mem_clr;
  logic [7:0] instruction_field;
  logic [AW:0] pc_inc;

  assign pc_inc = {1'b0, pc} + ONE_W;

  instruction_store #(
    .DEPTH(MEM_DEPTH),
    .WIDTH(8),
    .FILL(strobe_processor_pkg::NOP_OPCODE),
    .AW(AW)
  ) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(mem_wr),
    .wr_addr(wptr),
    .wr_data(port_wdata),
    .clr(mem_clr),
    .rd_addr(pc),
    .rd_data(instruction_field)
  );

  always_comb begin
    logic cond_true;
    logic do_move;
    logic from_skip;
    logic stop_end;
    logic stop_halt;
    logic [AW:0] target;
    logic [7:0] y_plus;
    logic [7:0] cap;
    logic [7:0] mask;
    cond_true = condition_in[instruction_field[2:0]] ^ instruction_field[strobe_processor_pkg::INVERT_BIT];
    do_move = 1'b0;
    from_skip = 1'b0;
    stop_end = 1'b0;
    stop_halt = 1'b0;
    target = pc_inc;
    y_plus = param_y + 8'h01;
    cap = {5'h00, instruction_field[2:0]};
    mask = 8'((9'h001 << param_y[3:0]) - 9'h001);
    next_state = state;
    next_pc = pc;
    next_wptr = wptr;
    next_label = label;
    next_x = param_x;
    next_y = param_y;
    next_z = param_z;
    next_cnt = overflow_countdown;
    next_wait_cnt = wait_cnt;
    next_autodec = autodec;
    next_imm_pend = imm_pend && !strobe_ready;
    next_imm_sel = imm_sel;
    next_prog_sel = prog_sel;
    next_halt = 1'b0;
    next_wdone = 1'b0;
    next_pint = 1'b0;
    mem_wr = 1'b0;
    mem_clr = 1'b0;

    if (x_wr) begin
      next_x = x_wdata;
      next_autodec = 1'b0;
    end
    if (y_wr) begin
      next_y = y_wdata;
    end
    if (z_wr) begin
      next_z = z_wdata;
    end
    if (cnt_wr) begin
      next_cnt = cnt_wdata;
    end

    if (state != strobe_processor_pkg::ST_IDLE) begin
      if (mac_overflow && overflow_countdown != 8'h00) begin
        next_cnt = overflow_countdown - 8'h01;
      end
      // Stale-X hazard: X keeps counting overflows until software rewrites it or the random instruction loads it
      if (autodec && mac_overflow && state != strobe_processor_pkg::ST_WAIT_X) begin
        next_x = param_x - 8'h01;
      end
    end

    if (state != strobe_processor_pkg::ST_IDLE && overflow_countdown == 8'h00) begin
      stop_end = 1'b1;
    end else if (!imm_pend) begin
      unique case (state)
        strobe_processor_pkg::ST_IDLE: begin
        end
        strobe_processor_pkg::ST_EXEC: begin
          if (!instruction_field[7]) begin
            do_move = 1'b1;
            if (cond_true) begin
              target = pc_inc + {{(AW-2){1'b0}}, instruction_field[6:4]};
              from_skip = 1'b1;
            end
          end else if (instruction_field[7:5] == strobe_processor_pkg::PFX_PROG_STROBE) begin
            if (instruction_field[4:0] == strobe_processor_pkg::SEL_HALT) begin
              stop_halt = 1'b1;
            end else begin
              next_prog_sel = instruction_field[4:0];
              next_state = strobe_processor_pkg::ST_ISSUE;
            end
          end else if (instruction_field[7:5] == strobe_processor_pkg::PFX_FIXED_WAIT) begin
            next_wait_cnt = (instruction_field[4:0] == 5'h00) ?
                            strobe_processor_pkg::FIXED_WAIT_ZERO_COUNT :
                            {1'b0, instruction_field[4:0]};
            next_autodec = 1'b1;
            next_state = strobe_processor_pkg::ST_WAIT_OVF;
          end else if (instruction_field[7:4] == strobe_processor_pkg::PFX_REPEAT) begin
            do_move = 1'b1;
            if (cond_true) begin
              target = {1'b0, label};
            end
          end else if (instruction_field[7:3] == strobe_processor_pkg::PFX_CAPPED_INC) begin
            do_move = 1'b1;
            next_y = (param_y == 8'hFF || y_plus >= cap) ? cap : y_plus;
          end else begin
            do_move = 1'b1;
            unique case (instruction_field)
              strobe_processor_pkg::OP_COMPARE_WAIT: begin
                do_move = 1'b0;
                next_autodec = 1'b1;
                next_state = strobe_processor_pkg::ST_WAIT_CMP;
              end
              strobe_processor_pkg::OP_REG_WAIT: begin
                if (param_x != 8'h00) begin
                  do_move = 1'b0;
                  next_state = strobe_processor_pkg::ST_WAIT_X;
                end else begin
                  next_wdone = 1'b1;
                end
              end
              strobe_processor_pkg::OP_LABEL: begin
                // Loop start on the last location points at itself
                next_label = (pc_inc >= DEPTH_W) ? pc : pc_inc[AW-1:0];
              end
              strobe_processor_pkg::OP_INTERRUPT: begin
                next_pint = 1'b1;
              end
              strobe_processor_pkg::OP_INC_Y: begin
                next_y = y_plus;
              end
              strobe_processor_pkg::OP_DEC_Y: begin
                next_y = param_y - 8'h01;
              end
              strobe_processor_pkg::OP_DEC_Z: begin
                next_z = param_z - 8'h01;
              end
              strobe_processor_pkg::OP_RANDOM: begin
                next_autodec = 1'b0;
                if (param_y == 8'h00 || param_y > 8'h08) begin
                  next_x = random_in;
                end else begin
                  next_x = random_in & mask;
                end
              end
              default: begin
                // Stray immediate codes and anything else fall through as no-operation
              end
            endcase
          end
        end
        strobe_processor_pkg::ST_ISSUE: begin
          if (strobe_ready) begin
            do_move = 1'b1;
          end
        end
        strobe_processor_pkg::ST_WAIT_OVF: begin
          if (mac_overflow) begin
            if (wait_cnt == 6'h01) begin
              do_move = 1'b1;
              next_wdone = 1'b1;
            end else begin
              next_wait_cnt = wait_cnt - 6'h01;
            end
          end
        end
        strobe_processor_pkg::ST_WAIT_X: begin
          if (mac_overflow) begin
            next_x = param_x - 8'h01;
            if (param_x == 8'h01) begin
              do_move = 1'b1;
              next_wdone = 1'b1;
            end
          end
        end
        strobe_processor_pkg::ST_WAIT_CMP: begin
          if (timer_at_compare) begin
            do_move = 1'b1;
          end
        end
        default: begin
          next_state = strobe_processor_pkg::ST_IDLE;
        end
      endcase
    end

    if (do_move) begin
      if (target >= DEPTH_W) begin
        next_state = strobe_processor_pkg::ST_IDLE;
        next_halt = !from_skip;
      end else begin
        next_pc = target[AW-1:0];
        next_state = strobe_processor_pkg::ST_EXEC;
      end
    end
    if (stop_end) begin
      // Program stays in memory for a rerun
      next_state = strobe_processor_pkg::ST_IDLE;
      next_halt = 1'b1;
    end
    if (stop_halt) begin
      next_state = strobe_processor_pkg::ST_IDLE;
      next_wptr = ADDR_ZERO;
      mem_clr = 1'b1;
      next_halt = 1'b1;
    end

    // Host port has the last word: immediate control beats program progress
    if (port_wr && port_wdata[7:5] == strobe_processor_pkg::PFX_IMM_STROBE) begin
      if (port_wdata[4:0] == strobe_processor_pkg::SEL_RUN) begin
        if (state == strobe_processor_pkg::ST_IDLE) begin
          next_state = strobe_processor_pkg::ST_EXEC;
          next_pc = ADDR_ZERO;
        end
      end else if (port_wdata[4:0] == strobe_processor_pkg::SEL_HALT) begin
        next_state = strobe_processor_pkg::ST_IDLE;
        next_wptr = ADDR_ZERO;
        mem_clr = 1'b1;
        next_halt = (state != strobe_processor_pkg::ST_IDLE);
      end else begin
        next_imm_pend = 1'b1;
        next_imm_sel = port_wdata[4:0];
      end
    end else if (port_wr) begin
      mem_wr = 1'b1;
      if (wptr != MEM_DEPTH[AW-1:0] - 1'b1) begin
        next_wptr = wptr + 1'b1;
      end
    end

    if (next_imm_pend || next_state == strobe_processor_pkg::ST_IDLE) begin
      next_rdata = strobe_processor_pkg::NOP_OPCODE;
    end else begin
      next_rdata = instruction_field;
    end
  end

  // Single clock domain; all sequencing runs at this rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= strobe_processor_pkg::ST_IDLE;
      pc <= ADDR_ZERO;
      wptr <= ADDR_ZERO;
      label <= ADDR_ZERO;
      param_x <= strobe_processor_pkg::PARAM_RESET;
      param_y <= strobe_processor_pkg::PARAM_RESET;
      param_z <= strobe_processor_pkg::PARAM_RESET;
      overflow_countdown <= strobe_processor_pkg::PARAM_RESET;
      wait_cnt <= 6'h00;
      autodec <= 1'b0;
      imm_pend <= 1'b0;
      imm_sel <= 5'h00;
      prog_sel <= 5'h00;
      port_rdata <= strobe_processor_pkg::NOP_OPCODE;
      halt_flag <= 1'b0;
      wait_done_flag <= 1'b0;
      program_interrupt_flag <= 1'b0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      wptr <= next_wptr;
      label <= next_label;
      param_x <= next_x;
      param_y <= next_y;
      param_z <= next_z;
      overflow_countdown <= next_cnt;
      wait_cnt <= next_wait_cnt;
      autodec <= next_autodec;
      imm_pend <= next_imm_pend;
      imm_sel <= next_imm_sel;
      prog_sel <= next_prog_sel;
      port_rdata <= next_rdata;
      halt_flag <= next_halt;
      wait_done_flag <= next_wdone;
      program_interrupt_flag <= next_pint;
    end
  end

  // Immediate strobe takes the radio port ahead of a pending program strobe
  assign strobe_valid = imm_pend || (state == strobe_processor_pkg::ST_ISSUE);
  assign strobe_sel = imm_pend ? imm_sel : prog_sel;
  assign running = (state != strobe_processor_pkg::ST_IDLE);
endmodule
`default_nettype wire

// *** verif/strobe_processor_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module strobe_processor_monitor #(
  parameter int MEM_DEPTH = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_wr,
  input wire logic [7:0] port_wdata,
  input wire logic [7:0] port_rdata,
  input wire logic cnt_wr,
  input wire logic [7:0] param_x,
  input wire logic [7:0] overflow_countdown,
  input wire logic mac_overflow,
  input wire logic strobe_valid,
  input wire logic [4:0] strobe_sel,
  input wire logic strobe_ready,
  input wire logic running,
  input wire logic halt_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] wdata_q;
  always_ff @(posedge clk) begin
    wdata_q <= port_wdata;
  end
  // Run and halt selectors written as immediate strobes stay inside and never reach the radio
  sequence imm_write;
    port_wr && port_wdata[7:5] == 3'b111 && port_wdata[4:1] != 4'hF;
  endsequence
  sequence run_write;
    !running && port_wr && port_wdata == 8'hFE;
  endsequence
  reset_values_a: assert property ($rose(rst_n) |-> port_rdata == 8'hC0 &&
    param_x == 8'h00 && !running)
    else $error("values after reset wrong");
  imm_issue_a: assert property (imm_write |=> strobe_valid &&
    strobe_sel == wdata_q[4:0])
    else $error("immediate strobe not offered");
  strobe_hold_a: assert property (strobe_valid && !strobe_ready && !port_wr
    |=> strobe_valid && $stable(strobe_sel))
    else $error("strobe dropped before accept");
  run_start_a: assert property (run_write |=> running)
    else $error("run strobe did not start");
  halt_idle_a: assert property (halt_flag |-> !running)
    else $error("halt flag while running");
  count_down_a: assert property (running && mac_overflow && !cnt_wr &&
    overflow_countdown != 8'h00 |=> overflow_countdown == $past(overflow_countdown) - 8'h01)
    else $error("countdown missed overflow");
  count_stop_a: assert property (running && overflow_countdown == 8'h00
    |-> ##[1:2] !running)
    else $error("zero countdown did not stop");
  strobe_cause_a: assert property ($rose(strobe_valid) |->
    $past(port_wr) || $past(running))
    else $error("strobe without cause");
  idle_read_a: assert property (!running [*2] |-> port_rdata == 8'hC0)
    else $error("idle read not no-operation");
endmodule
bind radio_strobe_coprocessor strobe_processor_monitor #(.MEM_DEPTH(MEM_DEPTH)) monitor (
  .clk(clk), .rst_n(rst_n), .port_wr(port_wr), .port_wdata(port_wdata),
  .port_rdata(port_rdata), .cnt_wr(cnt_wr), .param_x(param_x),
  .overflow_countdown(overflow_countdown), .mac_overflow(mac_overflow),
  .strobe_valid(strobe_valid), .strobe_sel(strobe_sel), .strobe_ready(strobe_ready),
  .running(running), .halt_flag(halt_flag));
`default_nettype wire

// *** verif/radio_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module radio_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe_valid,
  input wire logic [4:0] strobe_sel,
  input wire logic [3:0] latency,
  output logic strobe_ready,
  output logic [7:0] accepted,
  output logic [4:0] last_sel
);
  logic [3:0] stall;
  // A slow radio keeps the strobe waiting for latency cycles
  assign strobe_ready = strobe_valid && stall >= latency;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stall <= 4'h0;
      accepted <= 8'h00;
      last_sel <= 5'h00;
    end else if (strobe_valid && strobe_ready) begin
      stall <= 4'h0;
      accepted <= accepted + 8'h01;
      last_sel <= strobe_sel;
    end else if (strobe_valid) begin
      stall <= stall + 4'h1;
    end else begin
      stall <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** verif/radio_strobe_coprocessor_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module radio_strobe_coprocessor_test;
  logic clk, rst_n, port_wr, x_wr, y_wr, z_wr, cnt_wr, mac_overflow, timer_at_compare;
  logic [7:0] port_wdata, x_wdata, y_wdata, z_wdata, cnt_wdata, condition_in, random_in;
  logic [7:0] port_rdata, param_x, param_y, param_z, overflow_countdown, accepted, n;
  logic strobe_valid, strobe_ready, running, halt_flag, wait_done_flag, program_interrupt_flag;
  logic [4:0] strobe_sel, last_sel;
  logic [3:0] latency;
  logic [7:0] first_rd;
  int miscompares, num_checks, cycles, halts, ints, waits, sel5_accepts;
  radio_strobe_coprocessor dut (.clk(clk), .rst_n(rst_n), .port_wr(port_wr),
    .port_wdata(port_wdata), .port_rdata(port_rdata), .x_wr(x_wr), .x_wdata(x_wdata),
    .y_wr(y_wr), .y_wdata(y_wdata), .z_wr(z_wr), .z_wdata(z_wdata), .cnt_wr(cnt_wr),
    .cnt_wdata(cnt_wdata), .param_x(param_x), .param_y(param_y), .param_z(param_z),
    .overflow_countdown(overflow_countdown), .mac_overflow(mac_overflow),
    .timer_at_compare(timer_at_compare), .condition_in(condition_in), .random_in(random_in),
    .strobe_valid(strobe_valid), .strobe_sel(strobe_sel), .strobe_ready(strobe_ready),
    .running(running), .halt_flag(halt_flag), .wait_done_flag(wait_done_flag),
    .program_interrupt_flag(program_interrupt_flag));
  radio_model radio (.clk(clk), .rst_n(rst_n), .strobe_valid(strobe_valid),
    .strobe_sel(strobe_sel), .latency(latency), .strobe_ready(strobe_ready),
    .accepted(accepted), .last_sel(last_sel));
  always #5 clk = ~clk;
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (strobe_valid === 1'b1 && strobe_ready === 1'b1 && strobe_sel == 5'h05) sel5_accepts++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test;
    end
  end
  task automatic wr_port(input logic [7:0] b);
    @(posedge clk);
    port_wr <= 1'b1;
    port_wdata <= b;
    @(posedge clk);
    port_wr <= 1'b0;
  endtask
  // Register select: 0 countdown, 1 X, 2 Y, 3 Z
  task automatic wr_reg(input int which, input logic [7:0] v);
    @(posedge clk);
    {z_wr, y_wr, x_wr, cnt_wr} <= 4'(1 << which);
    {x_wdata, y_wdata, z_wdata, cnt_wdata} <= {4{v}};
    @(posedge clk);
    {z_wr, y_wr, x_wr, cnt_wr} <= 4'h0;
  endtask
  // Immediate halt first so each program starts from an empty memory at location zero
  task automatic load(input logic [7:0] p[$]);
    wr_port(8'hFF);
    foreach (p[i]) wr_port(p[i]);
  endtask
  task automatic run_wait;
    halts = 0;
    ints = 0;
    waits = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (i == 0) first_rd = port_rdata;
      halts += int'(halt_flag === 1'b1);
      ints += int'(program_interrupt_flag === 1'b1);
      waits += int'(wait_done_flag === 1'b1);
      if (running !== 1'b1) break;
    end
    @(posedge clk);
    #1;
    halts += int'(halt_flag === 1'b1);
  endtask
  task automatic run_ovf(input int k);
    wr_port(8'hFE);
    fork
      run_wait;
      repeat (k) begin
        repeat (3) @(posedge clk);
        mac_overflow <= 1'b1;
        @(posedge clk);
        mac_overflow <= 1'b0;
      end
    join
  endtask
  task automatic t_reset;
    `CHK("rdata", 8'hC0, port_rdata);
    `CHK("x", strobe_processor_pkg::PARAM_RESET, param_x);
    wr_reg(0, 8'hFF);
    wr_port(8'hFE);
    run_wait;
    `CHK("strobes", 8'(strobe_processor_pkg::MEM_DEPTH), accepted);
    `CHK("sel", 5'h00, last_sel);
    `CHK("halts", 1, halts);
    $display("test reset done");
  endtask
  task automatic t_immediate;
    n = accepted;
    latency <= 4'h2;
    wr_port(8'hE3);
    #1;
    `CHK("valid", 1'b1, strobe_valid);
    `CHK("sel", 5'h03, strobe_sel);
    repeat (5) @(posedge clk);
    #1;
    `CHK("acc", n + 8'h01, accepted);
    `CHK("sel", 5'h03, last_sel);
    `CHK("rdata", 8'hC0, port_rdata);
    latency <= 4'h0;
    $display("test immediate done");
  endtask
  task automatic t_program;
    load('{8'hB9, 8'hC5, 8'hBD, 8'hB6});
    n = accepted;
    wr_port(8'hFE);
    run_wait;
    `CHK("first", 8'hB9, first_rd);
    `CHK("ints", 1, ints);
    // One program strobe plus twenty filler no-operation strobes
    `CHK("acc", n + 8'h15, accepted);
    `CHK("sel5", 1, sel5_accepts);
    `CHK("sel", 5'h00, last_sel);
    `CHK("halts", 1, halts);
    `CHK("y", 8'h02, param_y);
    wr_port(8'hFE);
    run_wait;
    `CHK("y", 8'h04, param_y);
    $display("test program done");
  endtask
  task automatic t_halt;
    load('{8'hBD, 8'hDF, 8'hBD});
    wr_port(8'hFE);
    run_wait;
    `CHK("halts", 1, halts);
    `CHK("y", 8'h05, param_y);
    wr_port(8'hFE);
    run_wait;
    `CHK("y", 8'h05, param_y);
    wr_port(8'hBD);
    wr_port(8'hFE);
    run_wait;
    `CHK("y", 8'h06, param_y);
    condition_in <= 8'h00;
    load('{8'h18, 8'hBD, 8'hBD});
    wr_port(8'hFE);
    run_wait;
    `CHK("y", 8'h07, param_y);
    $display("test halt done");
  endtask
  task automatic t_waits;
    load('{8'hBB});
    wr_reg(1, 8'h02);
    wr_reg(0, 8'hFF);
    run_ovf(2);
    `CHK("x", 8'h00, param_x);
    `CHK("waits", 1, waits);
    `CHK("count", 8'hFD, overflow_countdown);
    load('{8'h82});
    wr_reg(0, 8'hFF);
    run_ovf(2);
    `CHK("waits", 1, waits);
    `CHK("x", 8'hFE, param_x);
    load('{8'h80});
    wr_reg(0, 8'h02);
    run_ovf(2);
    `CHK("halts", 1, halts);
    `CHK("waits", 0, waits);
    $display("test waits done");
  endtask
  task automatic t_ops;
    wr_reg(0, 8'hFF);
    wr_reg(2, 8'h03);
    wr_reg(3, 8'h10);
    load('{8'hBE, 8'hBF, 8'hBC, 8'hB8, 8'hA0, 8'hB2});
    wr_port(8'hFE);
    fork
      run_wait;
      begin
        repeat (10) @(posedge clk);
        #1;
        `CHK("rdata", 8'hB8, port_rdata);
        @(posedge clk);
        timer_at_compare <= 1'b1;
        @(posedge clk);
        timer_at_compare <= 1'b0;
      end
    join
    `CHK("y", 8'h02, param_y);
    `CHK("z", 8'h0F, param_z);
    `CHK("x", 8'hA5 & 8'h03, param_x);
    `CHK("halts", 1, halts);
    // Loop of increment and one-overflow wait, ended by the countdown
    load('{8'hBA, 8'hBD, 8'h81, 8'hA8});
    wr_reg(0, 8'h03);
    run_ovf(3);
    `CHK("y", 8'h05, param_y);
    `CHK("waits", 3, waits);
    `CHK("x", 8'hFE, param_x);
    `CHK("count", 8'h00, overflow_countdown);
    `CHK("halts", 1, halts);
    $display("test ops done");
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {port_wr, x_wr, y_wr, z_wr, cnt_wr, mac_overflow, timer_at_compare} = 7'h00;
    {port_wdata, x_wdata, y_wdata, z_wdata, cnt_wdata} = 40'h00_0000_0000;
    condition_in = 8'h00;
    random_in = 8'hA5;
    latency = 4'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset;
    t_immediate;
    t_program;
    t_halt;
    t_waits;
    t_ops;
    end_of_test;
  end
endmodule
`default_nettype wire
